// ===== logic/clock_input_select_fault_monitor.sv
// Purpose: Reference input selection, crystal path control and fault status for a clock generator.
// Assumes: All inputs synchronous to clock; loss monitors are supplied as live levels.
// Notes:   Configuration arrives as plain ports and is captured in a register on cfg_write.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Select code 00 picks input 0, 01 input 1, 10 input 2 and 11 the crystal pins.
// - A configuration bit chooses whether the select pins or the register-held code rule.
// - Select pins are pulled up, so an undriven pin (reported as floating) reads as one.
// - External-clock mode on the crystal pins switches the internal load capacitors off.
// - A programmable pre-divider on the crystal path divides fast external clocks down.
// - The precision variant ignores clock inputs and runs only from the crystal.
// - Signal loss on each input, the crystal and feedback, and lock loss, are each monitored.
// - Live status is readable and lock loss also drives a dedicated active-low pin.
// - Each status bit has a sticky flag set on any change of state, rise or fall, and held until software clears it.
// - Writing zero to a sticky flag clears it.
// - The interrupt pin asserts when any monitored status changes state.
// - A mask bit per source keeps that source from asserting the interrupt pin.
// - The interrupt pin deasserts only once every unmasked flag has been cleared.
// - Hard reset reloads configuration, masks and flags from non-volatile values before access; soft reset skips it.
module clock_input_select_fault_monitor (
  input  wire logic                                   clock,
  input  wire logic                                   rst,
  input  wire logic                                   clock_enable,
  input  wire logic                                   hard_reset_pin_n,
  input  wire logic                                   soft_reset,
  input  wire logic                                   precision_variant,
  input  wire logic [1:0]                             select_pins,
  input  wire logic [1:0]                             select_pins_floating,
  input  wire logic                                   cfg_write,
  input  wire clock_select_pkg::config_t              cfg_in,
  input  wire clock_select_pkg::config_t              nvm_config,
  input  wire logic [clock_select_pkg::NUM_STATUS-1:0] nvm_flags,
  input  wire logic                                   signal_loss_in0,
  input  wire logic                                   signal_loss_in1,
  input  wire logic                                   signal_loss_in2,
  input  wire logic                                   signal_loss_xtal,
  input  wire logic                                   signal_loss_feedback,
  input  wire logic                                   lock_loss,
  input  wire logic                                   flag_write,
  input  wire logic [clock_select_pkg::NUM_STATUS-1:0] flag_write_data,
  output logic                                        access_ready,
  output clock_select_pkg::ref_sel_t                  active_ref,
  output logic                                        load_caps_enable,
  output logic                                        xtal_oscillator_enable,
  output logic [clock_select_pkg::PREDIV_W-1:0]       crystal_path_predivider,
  output clock_select_pkg::config_t                   cfg_out,
  output logic [clock_select_pkg::NUM_STATUS-1:0]     live_status,
  output logic [clock_select_pkg::NUM_STATUS-1:0]     sticky_flag,
  output logic                                        lock_loss_pin_n,
  output logic                                        interrupt_pin_n
);
  clock_select_pkg::config_t               cfg_q;
  clock_select_pkg::config_t               cfg_d;
  clock_select_pkg::init_state_t           state_q;
  clock_select_pkg::init_state_t           state_d;
  logic [clock_select_pkg::LOAD_CNT_W-1:0] cnt_q;
  logic [clock_select_pkg::LOAD_CNT_W-1:0] cnt_d;
  clock_select_pkg::ref_sel_t              sel_d;
  clock_select_pkg::ref_sel_t              sel_q;
  logic [clock_select_pkg::NUM_STATUS-1:0] status_d;
  logic [clock_select_pkg::NUM_STATUS-1:0] status_q;
  logic                                    ext_clk_d;
  logic                                    ext_clk_q;
  logic                                    hard_q;
  logic                                    load;
  logic [1:0]                              pins_eff;

  // Hard reset is sampled as a level; while held the block stays in the load state.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      clock_select_pkg::ST_LOAD: begin
        if (cnt_q == clock_select_pkg::LOAD_CNT_W'(clock_select_pkg::LOAD_CYCLES - 1)) begin
          state_d = clock_select_pkg::ST_READY;
        end else begin
          cnt_d = cnt_q + 3'h1;
        end
      end
      clock_select_pkg::ST_READY: begin
        cnt_d = 3'h0;
      end
      default: begin
        state_d = clock_select_pkg::ST_LOAD;
        cnt_d   = 3'h0;
      end
    endcase
    if (!hard_reset_pin_n) begin
      state_d = clock_select_pkg::ST_LOAD;
      cnt_d   = 3'h0;
    end
  end

  assign load         = (state_q == clock_select_pkg::ST_LOAD);
  assign access_ready = (state_q == clock_select_pkg::ST_READY);

  // Soft reset deliberately leaves the configuration alone; it only restarts the sticky history.
  always_comb begin
    cfg_d = cfg_q;
    if (load) begin
      cfg_d = nvm_config;
    end else if (cfg_write) begin
      cfg_d = cfg_in;
    end
  end

  always_comb begin
    pins_eff = select_pins | select_pins_floating;
    if (precision_variant) begin
      sel_d = clock_select_pkg::SEL_XTAL;
    end else if (cfg_q.use_register_sel) begin
      sel_d = cfg_q.reg_sel;
    end else begin
      sel_d = clock_select_pkg::ref_sel_t'(pins_eff);
    end
    // The precision part must run its crystal as an oscillator, never as a clock input.
    ext_clk_d = cfg_q.xtal_external_clock & ~precision_variant;
    status_d  = '0;
    status_d[clock_select_pkg::STAT_IN0]  = signal_loss_in0;
    status_d[clock_select_pkg::STAT_IN1]  = signal_loss_in1;
    status_d[clock_select_pkg::STAT_IN2]  = signal_loss_in2;
    status_d[clock_select_pkg::STAT_XTAL] = signal_loss_xtal;
    status_d[clock_select_pkg::STAT_FB]   = signal_loss_feedback;
    status_d[clock_select_pkg::STAT_LOCK] = lock_loss;
    if (precision_variant) begin
      status_d[clock_select_pkg::STAT_IN0] = 1'b0;
      status_d[clock_select_pkg::STAT_IN1] = 1'b0;
      status_d[clock_select_pkg::STAT_IN2] = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q   <= clock_select_pkg::ST_LOAD;
      cnt_q     <= 3'h0;
      cfg_q     <= clock_select_pkg::CONFIG_RESET;
      sel_q     <= clock_select_pkg::SEL_XTAL;
      status_q  <= '0;
      ext_clk_q <= 1'b0;
      hard_q    <= 1'b0;
    end else if (clock_enable) begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      cfg_q     <= cfg_d;
      sel_q     <= sel_d;
      status_q  <= status_d;
      ext_clk_q <= ext_clk_d;
      hard_q    <= load;
    end
  end

  sticky_flags u_flags (
    .clock           (clock),
    .rst             (rst | soft_reset),
    .clock_enable    (clock_enable),
    .load            (load),
    .load_value      (nvm_flags),
    .status          (status_q),
    .mask            (cfg_q.mask),
    .flag_write      (flag_write & access_ready),
    .flag_write_data (flag_write_data),
    .sticky_flag     (sticky_flag),
    .interrupt_pin_n (interrupt_pin_n)
  );

  assign active_ref              = sel_q;
  assign xtal_oscillator_enable  = ~ext_clk_q & ~hard_q;
  assign load_caps_enable        = ~ext_clk_q;
  assign crystal_path_predivider = precision_variant ? 2'h0 : cfg_q.xtal_prediv;
  assign cfg_out                 = cfg_q;
  assign live_status             = status_q;
  assign lock_loss_pin_n         = ~status_q[clock_select_pkg::STAT_LOCK];
endmodule
`default_nettype wire

// ===== logic/clock_select_pkg.sv
// Purpose: Shared constants and carrier types for reference selection and fault monitoring.
// Assumes: One clock domain at 10 MHz, synchronous active-high reset.
// Notes:   Status vector order is input 0, input 1, input 2, crystal, feedback, lock.
`default_nettype none
package clock_select_pkg;
  localparam int unsigned NUM_STATUS   = 6;
  localparam int unsigned STAT_IN0     = 0;
  localparam int unsigned STAT_IN1     = 1;
  localparam int unsigned STAT_IN2     = 2;
  localparam int unsigned STAT_XTAL    = 3;
  localparam int unsigned STAT_FB      = 4;
  localparam int unsigned STAT_LOCK    = 5;
  localparam int unsigned PREDIV_W     = 2;
  localparam int unsigned LOAD_CYCLES  = 4;
  localparam int unsigned LOAD_CNT_W   = 3;

  typedef enum logic [1:0] {
    SEL_IN0  = 2'b00,
    SEL_IN1  = 2'b01,
    SEL_IN2  = 2'b10,
    SEL_XTAL = 2'b11
  } ref_sel_t;

  typedef struct packed {
    logic                  use_register_sel;
    ref_sel_t              reg_sel;
    logic                  xtal_external_clock;
    logic [PREDIV_W-1:0]   xtal_prediv;
    logic [NUM_STATUS-1:0] mask;
  } config_t;

  localparam config_t CONFIG_RESET = '{
    use_register_sel:    1'b0,
    reg_sel:             SEL_XTAL,
    xtal_external_clock: 1'b0,
    xtal_prediv:         2'h0,
    mask:                6'h00
  };

  typedef enum logic [1:0] {
    ST_LOAD  = 2'b00,
    ST_READY = 2'b01
  } init_state_t;
endpackage
`default_nettype wire

// ===== logic/sticky_flags.sv
// Purpose: Sticky fault flags with write-zero clear and masked interrupt output.
// Assumes: Status inputs are synchronous to clock.
// Notes:   A set in the same cycle as a clear wins, so no event is lost.
`timescale 1ns/1ps
`default_nettype none
module sticky_flags (
  input  wire logic                                   clock,
  input  wire logic                                   rst,
  input  wire logic                                   clock_enable,
  input  wire logic                                   load,
  input  wire logic [clock_select_pkg::NUM_STATUS-1:0] load_value,
  input  wire logic [clock_select_pkg::NUM_STATUS-1:0] status,
  input  wire logic [clock_select_pkg::NUM_STATUS-1:0] mask,
  input  wire logic                                   flag_write,
  input  wire logic [clock_select_pkg::NUM_STATUS-1:0] flag_write_data,
  output logic      [clock_select_pkg::NUM_STATUS-1:0] sticky_flag,
  output logic                                        interrupt_pin_n
);
  logic [clock_select_pkg::NUM_STATUS-1:0] flag_q;
  logic [clock_select_pkg::NUM_STATUS-1:0] flag_d;
  logic [clock_select_pkg::NUM_STATUS-1:0] status_q;
  logic [clock_select_pkg::NUM_STATUS-1:0] change;
  logic                                    irq_q;
  logic                                    irq_d;

  always_comb begin
    change = status ^ status_q;
    flag_d = flag_q;
    if (flag_write) begin
      flag_d = flag_q & flag_write_data;
    end
    // Any change of a status bit, rise or fall, latches its flag.
    flag_d = flag_d | change | status;
    if (load) begin
      flag_d = load_value;
    end
    irq_d = |(flag_d & ~mask);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flag_q   <= '0;
      status_q <= '0;
      irq_q    <= 1'b0;
    end else if (clock_enable) begin
      flag_q   <= flag_d;
      status_q <= status;
      irq_q    <= irq_d;
    end
  end

  assign sticky_flag     = flag_q;
  assign interrupt_pin_n = ~irq_q;
endmodule
`default_nettype wire

// ===== tb/fault_source_model.sv
// Purpose: Reference sources that fail and recover on command.
// Assumes: Loss levels are already synchronous to clock.
// Notes:   Faults change only at a clock edge, as a synchronised monitor would.
`timescale 1ns/1ps
`default_nettype none
module fault_source_model (
  input  wire logic                                    clock,
  input  wire logic [clock_select_pkg::NUM_STATUS-1:0] fault_cmd,
  output logic      [clock_select_pkg::NUM_STATUS-1:0] loss
);
  always_ff @(posedge clock) begin
    loss <= fault_cmd;
  end
endmodule
`default_nettype wire

// ===== tb/clock_select_sva.sv
// Purpose: Port-level checks of selection, crystal path and fault flags.
// Assumes: Bound to the top module.
// Notes:   Most checks wait for stable inputs, so one or two pipeline stages both pass.
`timescale 1ns/1ps
`default_nettype none
module clock_select_checker (
  input wire logic                                    clock,
  input wire logic                                    rst,
  input wire logic                                    clock_enable,
  input wire logic                                    soft_reset,
  input wire logic                                    precision_variant,
  input wire logic [1:0]                              select_pins,
  input wire logic [1:0]                              select_pins_floating,
  input wire logic                                    flag_write,
  input wire logic [clock_select_pkg::NUM_STATUS-1:0] flag_write_data,
  input wire logic                                    lock_loss,
  input wire logic                                    access_ready,
  input wire clock_select_pkg::ref_sel_t              active_ref,
  input wire logic                                    load_caps_enable,
  input wire logic [clock_select_pkg::PREDIV_W-1:0]   crystal_path_predivider,
  input wire clock_select_pkg::config_t               cfg_out,
  input wire logic [clock_select_pkg::NUM_STATUS-1:0] live_status,
  input wire logic [clock_select_pkg::NUM_STATUS-1:0] sticky_flag,
  input wire logic                                    lock_loss_pin_n,
  input wire logic                                    interrupt_pin_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic run;
  logic prec_prev;
  // The previous precision level is kept here, because a continuous assignment may not sample history.
  always_ff @(posedge clock) begin
    prec_prev <= precision_variant;
  end
  assign run = clock_enable && access_ready && !precision_variant && !prec_prev;
  AST_PIN_SEL: assert property (run && !cfg_out.use_register_sel && $stable(select_pins)
    && $stable(select_pins_floating) |=> active_ref == $past(select_pins | select_pins_floating))
    else $error("pin selection wrong");
  AST_REG_SEL: assert property (run && cfg_out.use_register_sel && $stable(cfg_out)
    |=> active_ref == $past(cfg_out.reg_sel)) else $error("register selection wrong");
  AST_CAPS: assert property (run && cfg_out.xtal_external_clock && $past(cfg_out.xtal_external_clock)
    |-> !load_caps_enable) else $error("load caps on in clock mode");
  AST_PREDIV: assert property (run && $stable(cfg_out)
    |-> crystal_path_predivider == cfg_out.xtal_prediv) else $error("predivider wrong");
  AST_PRECISION: assert property (precision_variant && $past(precision_variant) && access_ready
    |-> active_ref == clock_select_pkg::SEL_XTAL && crystal_path_predivider == 2'h0)
    else $error("precision variant not on crystal");
  AST_LIVE: assert property (clock_enable && access_ready && $past(access_ready)
    |-> live_status[5] == $past(lock_loss)) else $error("live lock status wrong");
  AST_LOCK_PIN: assert property (lock_loss_pin_n == !live_status[5])
    else $error("lock pin wrong");
  AST_FLAG_SET: assert property (access_ready && clock_enable && !soft_reset && live_status[5]
    |=> sticky_flag[5]) else $error("flag not set");
  AST_CLEAR: assert property (access_ready && $past(flag_write && clock_enable && access_ready)
    && !$past(soft_reset) && live_status == 6'h00 && $past(live_status) == 6'h00
    && $past(live_status, 2) == 6'h00 |-> sticky_flag == ($past(sticky_flag) & $past(flag_write_data)))
    else $error("flag clear wrong");
  AST_IRQ: assert property (access_ready && $stable(cfg_out) && $stable(sticky_flag)
    |-> interrupt_pin_n == !(|(sticky_flag & ~cfg_out.mask))) else $error("interrupt pin wrong");
  AST_RESET: assert property (disable iff (1'b0) rst |=> !access_ready)
    else $error("access allowed in reset");
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Directed tests of selection, crystal path, faults and resets.
// Assumes: Design outputs settle before the bench samples them.
// Notes:   Stimulus is applied by non-blocking assignment at rising edges.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam clock_select_pkg::config_t NVM = '{use_register_sel: 1'b0, reg_sel: clock_select_pkg::SEL_IN1,
    xtal_external_clock: 1'b0, xtal_prediv: 2'h1, mask: 6'h00};
  logic clock = 1'b0, rst = 1'b1, clock_enable = 1'b1, hard_reset_pin_n = 1'b1, soft_reset = 1'b0;
  logic precision_variant = 1'b0, cfg_write = 1'b0, flag_write = 1'b0, access_ready, load_caps_enable;
  logic [1:0] select_pins = 2'h0, select_pins_floating = 2'h3, crystal_path_predivider;
  logic [5:0] fault_cmd = 6'h00, flag_write_data = 6'h3F, loss, live_status, sticky_flag;
  logic lock_loss_pin_n, interrupt_pin_n, xtal_oscillator_enable;
  clock_select_pkg::config_t cfg_in = NVM, cfg_out;
  clock_select_pkg::ref_sel_t active_ref;
  int num_errors = 0, checks_done = 0, cycles = 0;
  always #50 clock = ~clock;
  fault_source_model i_fault_source_model (.clock, .fault_cmd, .loss);
  clock_input_select_fault_monitor i_clock_input_select_fault_monitor (.clock, .rst, .clock_enable,
    .hard_reset_pin_n, .soft_reset, .precision_variant, .select_pins, .select_pins_floating, .cfg_write,
    .cfg_in, .nvm_config(NVM), .nvm_flags(6'h00), .signal_loss_in0(loss[0]), .signal_loss_in1(loss[1]),
    .signal_loss_in2(loss[2]), .signal_loss_xtal(loss[3]), .signal_loss_feedback(loss[4]), .lock_loss(loss[5]),
    .flag_write, .flag_write_data, .access_ready, .active_ref, .load_caps_enable, .xtal_oscillator_enable,
    .crystal_path_predivider, .cfg_out, .live_status, .sticky_flag, .lock_loss_pin_n, .interrupt_pin_n);
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // The whole run needs well under a thousand cycles; this ceiling only catches a hang.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors = num_errors + 1;
      tally_and_finish();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cfg_wr(input clock_select_pkg::config_t c);
    @(posedge clock);
    cfg_in <= c;
    cfg_write <= 1'b1;
    @(posedge clock);
    cfg_write <= 1'b0;
    tick(3);
  endtask
  task automatic flag_clr(input logic [5:0] d);
    @(posedge clock);
    flag_write_data <= d;
    flag_write <= 1'b1;
    @(posedge clock);
    flag_write <= 1'b0;
    tick(2);
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (access_ready !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    check("access_ready", access_ready, 1'b1);
    check("cfg_reload", cfg_out, NVM);
  endtask
  initial begin
    clock_select_pkg::config_t c;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    wait_ready();
    check("floating_sel", active_ref, 2'h3);
    for (int i = 0; i < 4; i++) begin
      // Every pass after the first finds register selection left on; hand control back to the pins first.
      cfg_wr(NVM);
      @(posedge clock);
      select_pins <= i[1:0];
      select_pins_floating <= 2'h0;
      tick(3);
      check("pin_select", active_ref, i);
      c = NVM;
      c.use_register_sel = 1'b1;
      c.reg_sel = clock_select_pkg::ref_sel_t'(2'(3 - i));
      cfg_wr(c);
      check("reg_select", active_ref, 3 - i);
    end
    c = NVM;
    c.xtal_external_clock = 1'b1;
    c.xtal_prediv = 2'h3;
    cfg_wr(c);
    check("load_caps", load_caps_enable, 1'b0);
    check("osc_off", xtal_oscillator_enable, 1'b0);
    check("prediv", crystal_path_predivider, 2'h3);
    @(posedge clock);
    precision_variant <= 1'b1;
    tick(3);
    check("prec_ref", active_ref, 2'h3);
    check("prec_prediv", crystal_path_predivider, 2'h0);
    @(posedge clock);
    precision_variant <= 1'b0;
    cfg_wr(NVM);
    check("osc_on", xtal_oscillator_enable, 1'b1);
    check("caps_on", load_caps_enable, 1'b1);
    $display("test selection done");
    for (int b = 0; b < 6; b++) begin
      @(posedge clock);
      fault_cmd <= 6'h01 << b;
      tick(5);
      check("live", live_status, 32'h1 << b);
      check("lock_pin", lock_loss_pin_n, b != 5);
      check("irq_set", interrupt_pin_n, 1'b0);
      @(posedge clock);
      fault_cmd <= 6'h00;
      tick(5);
      check("flag_held", sticky_flag, 32'h1 << b);
      flag_clr(~(6'h01 << b));
      check("flag_clr", sticky_flag, 6'h00);
      check("irq_clr", interrupt_pin_n, 1'b1);
    end
    $display("test faults done");
    c = NVM;
    c.mask = 6'h3F;
    cfg_wr(c);
    @(posedge clock);
    fault_cmd <= 6'h20;
    tick(5);
    check("masked_flag", sticky_flag, 6'h20);
    check("masked_irq", interrupt_pin_n, 1'b1);
    @(posedge clock);
    fault_cmd <= 6'h00;
    tick(5);
    @(posedge clock);
    soft_reset <= 1'b1;
    @(posedge clock);
    soft_reset <= 1'b0;
    tick(2);
    check("soft_flags", sticky_flag, 6'h00);
    check("soft_cfg", cfg_out, c);
    @(posedge clock);
    hard_reset_pin_n <= 1'b0;
    tick(2);
    check("hard_busy", access_ready, 1'b0);
    @(posedge clock);
    hard_reset_pin_n <= 1'b1;
    wait_ready();
    $display("test resets done");
    tally_and_finish();
  end
endmodule
bind clock_input_select_fault_monitor clock_select_checker i_clock_select_checker (.clock, .rst, .clock_enable,
  .soft_reset, .precision_variant, .select_pins, .select_pins_floating, .flag_write, .flag_write_data,
  .lock_loss, .access_ready, .active_ref, .load_caps_enable, .crystal_path_predivider, .cfg_out,
  .live_status, .sticky_flag, .lock_loss_pin_n, .interrupt_pin_n);
`default_nettype wire
